// >>> sad_pkg.sv
// package of constants and carriers for the slave address detection block
// Notes on behaviour
// RL1 - slave address valid range zero to 254
// RL2 - address 255 means no id, flag error
// RL3 - output id is address, input id 0x200+address
// RL4 - address selects start bit, points run upward
// RL5 - assigner keeps same-direction bit ranges apart
// RL6 - address zero maps to image bit 0
// RL7 - occupied bits stay within transmission points
// RL8 - stored address kept until new write
// RL9 - parameter writes refused on line error
// RL10 - parameter writes refused five seconds after reset
// RL11 - parameter writes refused while learning runs
// RL12 - learning collects ids into nonvolatile store
// RL13 - parameter copies refreshed after id storage
// RL14 - learned ids persist, error lists volatile
// RL15 - learning starts from switch hold or request
// RL16 - switch held: led on, active bit set
// RL17 - led flashes while learning, off when stored
// RL18 - active bit drops only when sequence done
// RL19 - host holds request until active seen
// RL20 - request ignored unless access done, inactive
// RL21 - learning step starts 0.5 s after led off
// RL22 - active bit stays high until completion
package sad_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned MAX_SLAVES    = 8;
  localparam int unsigned SLOT_W        = 3;
  localparam int unsigned IMG_W         = 256;
  localparam logic [7:0]  ADDR_MAX      = 8'hFE;
  localparam logic [7:0]  ADDR_NONE     = 8'hFF;
  localparam logic [9:0]  ID_IN_BASE    = 10'h200;
  localparam int unsigned BOOT_MS       = 5000;
  localparam int unsigned START_DLY_MS  = 500;
  localparam int unsigned HOLD_MS       = 2000;
  localparam int unsigned FLASH_MS      = 1000;
  localparam int unsigned BLINK_MS      = 250;
  localparam int unsigned BOOT_CYC      = (CLK_HZ / 1000) * BOOT_MS;
  localparam int unsigned START_DLY_CYC = (CLK_HZ / 1000) * START_DLY_MS;
  localparam int unsigned HOLD_CYC      = (CLK_HZ / 1000) * HOLD_MS;
  localparam int unsigned FLASH_CYC     = (CLK_HZ / 1000) * FLASH_MS;
  localparam int unsigned BLINK_CYC     = (CLK_HZ / 1000) * BLINK_MS;

  typedef struct packed {
    logic       present;
    logic       is_input;
    logic [7:0] addr;
    logic [2:0] points;
  } sad_slave_s;

  typedef enum logic [2:0] {
    SAD_IDLE  = 3'b000,
    SAD_ARMED = 3'b001,
    SAD_FLASH = 3'b011,
    SAD_WAIT  = 3'b010,
    SAD_SCAN  = 3'b110,
    SAD_REFR  = 3'b111
  } sad_state_e;

  function automatic logic [9:0] sad_id(input logic is_input, input logic [7:0] addr);
    sad_id = is_input ? (ID_IN_BASE | {2'b00, addr}) : {2'b00, addr};
  endfunction
endpackage

// >>> sad_top.sv
// slave address detection: id learning sequence, write gating and image map
`timescale 1ns/10ps
module sad_top
  import sad_pkg::*;
#(
  parameter int unsigned P_BOOT_CYC      = BOOT_CYC,
  parameter int unsigned P_START_DLY_CYC = START_DLY_CYC,
  parameter int unsigned P_HOLD_CYC      = HOLD_CYC,
  parameter int unsigned P_FLASH_CYC     = FLASH_CYC,
  parameter int unsigned P_BLINK_CYC     = BLINK_CYC
)
(
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_set_switch,
  input  wire logic                    i_id_learn_request,
  input  wire logic                    i_param_access_done,
  input  wire logic                    i_line_error,
  input  wire sad_slave_s              i_slave,
  input  wire logic [SLOT_W-1:0]       i_slave_idx,
  input  wire logic                    i_param_wr,
  input  wire logic [8:0]              i_tx_points,
  input  wire logic [IMG_W-1:0]        i_input_bits,
  input  wire logic [IMG_W-1:0]        i_first_output_image_word,
  output logic                         o_param_wr_ok,
  output logic                         o_param_wr_refused,
  output logic                         o_learn_active,
  output logic                         o_set_led,
  output logic                         o_no_id_error,
  output logic                         o_dup_id_error,
  output logic                         o_nv_we,
  output logic [SLOT_W-1:0]            o_nv_slot,
  output logic [9:0]                   o_nv_id,
  output logic                         o_refresh_pulse,
  output logic [9:0]                   o_learned_id [MAX_SLAVES],
  output logic [MAX_SLAVES-1:0]        o_learned_valid,
  output logic [MAX_SLAVES-1:0]        o_out_bits [MAX_SLAVES],
  output logic [IMG_W-1:0]             o_input_image
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sw_sync_r;
  logic [1:0] req_sync_r;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sw_sync_r  <= 2'b00;
      req_sync_r <= 2'b00;
    end
    else
    begin
      sw_sync_r  <= {sw_sync_r[0], i_set_switch};
      req_sync_r <= {req_sync_r[0], i_id_learn_request};
    end
  end
  wire logic sw_q  = sw_sync_r[1];
  wire logic req_q = req_sync_r[1];

  // ----------------------------------------------------------------
  // boot holdoff after reset
  // ----------------------------------------------------------------
  logic [31:0] boot_cnt_r;
  logic        boot_done_r;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      boot_cnt_r  <= 32'h0000_0000;
      boot_done_r <= 1'b0;
    end
    else if (!boot_done_r)
    begin
      boot_cnt_r  <= boot_cnt_r + 32'h0000_0001;
      boot_done_r <= (boot_cnt_r >= P_BOOT_CYC - 1); // RL10
    end
  end

  // ----------------------------------------------------------------
  // learning sequence
  // ----------------------------------------------------------------
  sad_state_e        state_r;
  logic [31:0]       tmr_r;
  logic [31:0]       hold_r;
  logic [SLOT_W-1:0] scan_r;
  logic [9:0]        id_r [MAX_SLAVES];
  logic [MAX_SLAVES-1:0] vld_r;
  logic [2:0]        pts_r [MAX_SLAVES];
  logic              no_id_r;
  logic              dup_r;
  logic              nv_we_r;
  logic [SLOT_W-1:0] nv_slot_r;
  logic [9:0]        nv_id_r;
  logic              refr_r;

  wire logic learn_ok = i_param_access_done && (state_r == SAD_IDLE)
                        && boot_done_r && !i_line_error;
  wire logic sw_start  = sw_q && (hold_r >= P_HOLD_CYC - 1);                 // RL15
  wire logic req_start = req_q;                                              // RL15

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || state_r != SAD_IDLE || !sw_q)
      hold_r <= 32'h0000_0000;
    else if (hold_r < P_HOLD_CYC)
      hold_r <= hold_r + 32'h0000_0001;
  end

  wire logic [9:0] cur_id = sad_id(i_slave.is_input, i_slave.addr);          // RL3

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_r   <= SAD_IDLE;
      tmr_r     <= 32'h0000_0000;
      scan_r    <= '0;
      no_id_r   <= 1'b0;
      dup_r     <= 1'b0;
      nv_we_r   <= 1'b0;
      nv_slot_r <= '0;
      nv_id_r   <= 10'h000;
      refr_r    <= 1'b0;
    end
    else
    begin
      nv_we_r <= 1'b0;
      refr_r  <= 1'b0;
      case (state_r)
        SAD_IDLE:
        begin
          if (learn_ok && (sw_start || req_start))                           // RL20
          begin
            state_r <= SAD_ARMED;                                            // RL16
            tmr_r   <= 32'h0000_0000;
          end
        end
        SAD_ARMED:
        begin
          // led held on until switch and request both released
          if (!sw_q && !req_q)                                               // RL19
            state_r <= SAD_FLASH;
        end
        SAD_FLASH:
        begin
          tmr_r <= tmr_r + 32'h0000_0001;
          if (tmr_r >= P_FLASH_CYC - 1)                                      // RL17
          begin
            state_r <= SAD_WAIT;
            tmr_r   <= 32'h0000_0000;
          end
        end
        SAD_WAIT:
        begin
          tmr_r <= tmr_r + 32'h0000_0001;
          if (tmr_r >= P_START_DLY_CYC - 1)                                  // RL21
          begin
            state_r <= SAD_SCAN;
            scan_r  <= '0;
            no_id_r <= 1'b0;                                                 // RL14
            dup_r   <= 1'b0;
          end
        end
        SAD_SCAN:
        begin
          if (i_slave_idx == scan_r)
          begin
            if (i_slave.present && i_slave.addr == ADDR_NONE)
              no_id_r <= 1'b1;                                               // RL2
            else if (i_slave.present)
            begin
              for (int k = 0; k < MAX_SLAVES; k++)
                if (k < scan_r && vld_r[k] && id_r[k] == cur_id)
                  dup_r <= 1'b1;
              nv_we_r   <= 1'b1;                                             // RL12
              nv_slot_r <= scan_r;
              nv_id_r   <= cur_id;
            end
            if (scan_r == SLOT_W'(MAX_SLAVES - 1))
              state_r <= SAD_REFR;
            else
              scan_r <= scan_r + 1'b1;
          end
        end
        SAD_REFR:
        begin
          refr_r  <= 1'b1;                                                   // RL13
          state_r <= SAD_IDLE;                                               // RL18
        end
        default:
          state_r <= SAD_IDLE;
      endcase
    end
  end

  // learned ids stay put across reset; cleared only by a new scan
  always_ff @(posedge i_clk)
  begin
    if (state_r == SAD_SCAN && i_slave_idx == scan_r)                        // RL14
    begin
      id_r[scan_r]  <= cur_id;
      pts_r[scan_r] <= i_slave.points;                                       // RL4
      vld_r[scan_r] <= i_slave.present && i_slave.addr <= ADDR_MAX;          // RL1
    end
  end

  // ----------------------------------------------------------------
  // led and status
  // ----------------------------------------------------------------
  logic [31:0] blink_r;
  logic        blink_ph_r;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || state_r != SAD_FLASH)
    begin
      blink_r    <= 32'h0000_0000;
      blink_ph_r <= 1'b1;
    end
    else if (blink_r >= P_BLINK_CYC - 1)
    begin
      blink_r    <= 32'h0000_0000;
      blink_ph_r <= ~blink_ph_r;
    end
    else
      blink_r <= blink_r + 32'h0000_0001;
  end

  assign o_learn_active = (state_r != SAD_IDLE);                             // RL22
  assign o_set_led      = (state_r == SAD_ARMED) ||
                          (state_r == SAD_FLASH && blink_ph_r);              // RL17
  assign o_no_id_error  = no_id_r;
  assign o_dup_id_error = dup_r;
  assign o_nv_we        = nv_we_r;
  assign o_nv_slot      = nv_slot_r;
  assign o_nv_id        = nv_id_r;
  assign o_refresh_pulse = refr_r;
  assign o_learned_id   = id_r;
  assign o_learned_valid = vld_r;

  // ----------------------------------------------------------------
  // parameter write gating
  // ----------------------------------------------------------------
  wire logic wr_block = i_line_error                                         // RL9
                        || !boot_done_r                                      // RL10
                        || o_learn_active;                                   // RL11
  assign o_param_wr_ok      = i_param_wr && !wr_block;                       // RL8
  assign o_param_wr_refused = i_param_wr && wr_block;

  // ----------------------------------------------------------------
  // remote image mapping
  // ----------------------------------------------------------------
  function automatic logic [7:0] sad_bit(input logic [7:0] start, input int unsigned p);
    sad_bit = start + 8'(p);                                                 // RL4
  endfunction

  // a slave owns only as many bits as it has points; the position is widened
  // so a start near the top of the image cannot wrap below the point limit
  function automatic logic sad_fits(input logic [7:0]  start,
                                    input int unsigned p,
                                    input logic [2:0]  pts,
                                    input logic [8:0]  tx);
    logic [8:0] pos;
    pos      = {1'b0, start} + 9'(p);
    sad_fits = (3'(p) < pts) && (pos < tx);                                  // RL4
  endfunction

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_input_image <= '0;
    else
      o_input_image <= i_input_bits;
  end

  for (genvar s = 0; s < MAX_SLAVES; s++)
  begin : g_out
    always_ff @(posedge i_clk)
    begin
      if (i_sys_rst)
        o_out_bits[s] <= '0;
      else
        for (int p = 0; p < MAX_SLAVES; p++)
          o_out_bits[s][p] <= vld_r[s] && !id_r[s][9]
                              && sad_fits(id_r[s][7:0], p, pts_r[s], i_tx_points)
                              && i_first_output_image_word[sad_bit(id_r[s][7:0], p)]; // RL6
    end
  end

endmodule

// >>> sad_top_asserts.sv
// assertion checker for the slave address detection block
`timescale 1ns/10ps
module sad_top_asserts
  import sad_pkg::*;
#(
  parameter int unsigned P_BOOT_CYC = BOOT_CYC
)
(
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_line_error,
  input wire logic       i_param_access_done,
  input wire logic       i_param_wr,
  input wire logic       o_param_wr_ok,
  input wire logic       o_param_wr_refused,
  input wire logic       o_learn_active,
  input wire logic       o_set_led,
  input wire logic       o_nv_we,
  input wire logic [9:0] o_nv_id,
  input wire logic       o_refresh_pulse
);
  int unsigned boot_cnt_r;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      boot_cnt_r <= 0;
    else if (boot_cnt_r < P_BOOT_CYC)
      boot_cnt_r <= boot_cnt_r + 1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_err_refuse:
    assert property (i_param_wr && i_line_error |-> o_param_wr_refused && !o_param_wr_ok)
    else $error("write accepted during line error");
  a_boot_refuse:
    assert property (i_param_wr && boot_cnt_r + 1 < P_BOOT_CYC |-> o_param_wr_refused)
    else $error("write accepted during boot holdoff");
  a_learn_refuse:
    assert property (i_param_wr && o_learn_active |-> o_param_wr_refused)
    else $error("write accepted while learning");
  a_request_ignored:
    assert property (!i_param_access_done || i_line_error |=> !$rose(o_learn_active))
    else $error("learning started while not allowed");
  a_led_with_active:
    assert property ($rose(o_learn_active) |-> o_set_led)
    else $error("led not lit with active bit");
  a_led_idle_off:
    assert property (!o_learn_active |-> !o_set_led)
    else $error("led lit while idle");
  a_nv_id_form:
    assert property (o_nv_we |-> o_learn_active && !o_set_led && o_nv_id[7:0] != ADDR_NONE
      && o_nv_id[8] == 1'b0)
    else $error("bad stored id or store outside scan");
  a_active_until_end:
    assert property ($fell(o_learn_active) |->
      o_refresh_pulse || $past(o_refresh_pulse) || $past(o_refresh_pulse, 2))
    else $error("active bit dropped before refresh");
  c_start: cover property ($rose(o_learn_active));
  c_store: cover property (o_nv_we);
  c_done: cover property ($fell(o_learn_active));
endmodule
bind sad_top sad_top_asserts #(.P_BOOT_CYC(P_BOOT_CYC)) chk_u (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_line_error(i_line_error),
  .i_param_access_done(i_param_access_done), .i_param_wr(i_param_wr),
  .o_param_wr_ok(o_param_wr_ok), .o_param_wr_refused(o_param_wr_refused),
  .o_learn_active(o_learn_active), .o_set_led(o_set_led), .o_nv_we(o_nv_we),
  .o_nv_id(o_nv_id), .o_refresh_pulse(o_refresh_pulse));

// >>> sad_field_slaves.sv
// field slave table that answers the slot scan of the bridge
`timescale 1ns/10ps
module sad_field_slaves
  import sad_pkg::*;
(
  input  wire logic         i_clk,
  output logic [SLOT_W-1:0] o_slave_idx,
  output sad_slave_s        o_slave
);
  sad_slave_s tbl [MAX_SLAVES];
  // slot 5 is unset and slot 6 copies slot 0 on purpose
  initial
  begin
    o_slave_idx = '0;
    tbl[0] = '{1'b1, 1'b0, 8'h00, 3'h2};
    tbl[1] = '{1'b1, 1'b0, 8'h02, 3'h2};
    tbl[2] = '{1'b1, 1'b1, 8'h00, 3'h2};
    tbl[3] = '{1'b1, 1'b1, 8'h02, 3'h1};
    tbl[4] = '{1'b1, 1'b1, 8'h03, 3'h2};
    tbl[5] = '{1'b1, 1'b0, 8'hFF, 3'h1};
    tbl[6] = '{1'b1, 1'b0, 8'h00, 3'h2};
    tbl[7] = '{1'b0, 1'b0, 8'h00, 3'h0};
  end
  // addresses never change here, the scan visits one slot per clock
  always @(negedge i_clk)
    o_slave_idx <= o_slave_idx + 1'b1;
  assign o_slave = tbl[o_slave_idx];
endmodule

// >>> sad_top_bench.sv
// self-checking bench for the slave address detection block
`timescale 1ns/10ps
module sad_top_bench
  import sad_pkg::*;
  ;
  localparam int unsigned BOOT = 20;
  localparam int unsigned DLY  = 10;
  logic clk = 1'b0, rst = 1'b1, sw = 1'b0, req = 1'b0, acc = 1'b1, lerr = 1'b0, wr = 1'b0;
  logic [8:0]            tx_pts = 9'h100;
  logic [IMG_W-1:0]      in_img = {16{16'hC3A5}}, out_img = {16{16'h5A1E}}, inimg;
  sad_slave_s            slave;
  logic [SLOT_W-1:0]     idx;
  logic                  ok, refd, act, led, noid, dupid, nvwe, refr;
  logic [SLOT_W-1:0]     nslot;
  logic [9:0]            nid;
  logic [9:0]            lid [MAX_SLAVES];
  logic [MAX_SLAVES-1:0] lval, obits [MAX_SLAVES];
  int                    failures = 0, total_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  sad_field_slaves part_u (.i_clk(clk), .o_slave_idx(idx), .o_slave(slave));
  sad_top #(.P_BOOT_CYC(BOOT), .P_START_DLY_CYC(DLY), .P_HOLD_CYC(10), .P_FLASH_CYC(10),
    .P_BLINK_CYC(2)) dut_u (.i_clk(clk), .i_sys_rst(rst), .i_set_switch(sw),
    .i_id_learn_request(req), .i_param_access_done(acc), .i_line_error(lerr),
    .i_slave(slave), .i_slave_idx(idx), .i_param_wr(wr), .i_tx_points(tx_pts),
    .i_input_bits(in_img), .i_first_output_image_word(out_img), .o_param_wr_ok(ok),
    .o_param_wr_refused(refd), .o_learn_active(act), .o_set_led(led),
    .o_no_id_error(noid), .o_dup_id_error(dupid), .o_nv_we(nvwe), .o_nv_slot(nslot),
    .o_nv_id(nid), .o_refresh_pulse(refr), .o_learned_id(lid), .o_learned_valid(lval),
    .o_out_bits(obits), .o_input_image(inimg));
  task automatic end_of_test();
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [IMG_W-1:0] seen, input logic [IMG_W-1:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      failures++;
      end_of_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_try(input logic exp_ok);
    @(negedge clk);
    wr = 1'b1;
    #1;
    check(ok, exp_ok);
    check(refd, !exp_ok);
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic t_boot();
    wr_try(1'b0);
    req = 1'b1;
    tick(6);
    req = 1'b0;
    check(act, 1'b0);
    tick(BOOT);
  endtask
  task automatic t_refuse();
    lerr = 1'b1;
    wr_try(1'b0);
    req = 1'b1;
    tick(8);
    check(act, 1'b0);
    lerr = 1'b0;
    acc = 1'b0;
    tick(8);
    check(act, 1'b0);
    req = 1'b0;
    tick(4);
    acc = 1'b1;
    wr_try(1'b1);
  endtask
  task automatic t_learn(input logic by_sw);
    int n, last, first, seen, wcnt;
    logic [9:0] wid;
    n = 0;
    last = 0;
    first = 0;
    seen = 0;
    wcnt = 0;
    wid = 10'h3FF;
    sw = by_sw;
    req = !by_sw;
    while (act !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    check(act, 1'b1);
    check(led, 1'b1);
    wr_try(1'b0);
    sw = 1'b0;
    req = 1'b0;
    while (act === 1'b1 && cyc < 7000)
    begin
      tick(1);
      if (led === 1'b1) last = cyc;
      if (nvwe === 1'b1 && first == 0) first = cyc;
      if (nvwe === 1'b1) wcnt++;
      if (nvwe === 1'b1 && nslot === 3'h2) wid = nid;
      if (refr === 1'b1) seen = 1;
    end
    check(first - last >= DLY, 1'b1);
    check(seen, 1);
    check(led, 1'b0);
    check(lid[0], 10'h000);
    check(lid[1], 10'h002);
    check(lid[2], 10'h200);
    check(lid[4], 10'h203);
    check(lval[4:0], 5'h1F);
    check(lval[7], 1'b0);
    check(lval[6:5], 2'b10);
    check(wcnt, 6);
    check(wid, 10'h200);
    check(noid, 1'b1);
    check(dupid, 1'b1);
    check(obits[0], 8'h02);
    check(obits[1], 8'h03);
    check(obits[2], 8'h00);
    wr_try(1'b1);
  endtask
  task automatic t_persist();
    check(inimg, in_img);
    rst = 1'b1;
    tick(6);
    rst = 1'b0;
    tick(2);
    check(lid[2], 10'h200);
    check(act, 1'b0);
    wr_try(1'b0);
  endtask
  initial
  begin
    tick(6);
    rst = 1'b0;
    t_boot();
    t_refuse();
    t_learn(1'b0);
    t_learn(1'b1);
    t_persist();
    end_of_test();
  end
endmodule
